//--- sim/ipds_pins.sv
`timescale 1ns/1ns
// board pins: one flop stands for pad and trace delay, so level changes land one cycle later, on a rising bus edge
module ipds_pins (
   input wire pclk,
   input wire [2:0] lvl,
   output reg [2:0] pins
);
   always @(posedge pclk) begin
      pins <= lvl;
   end
endmodule // ipds_pins

//--- sim/ipds_regs_props.sv
`timescale 1ns/1ns
`include "ipds_defs.vh"
module ipds_props (
   // apb
   input wire pclk, presetn, psel, penable, pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   // pins
   input wire aux_input_pin_two, pin_one_buf_en, pin_one_alt_en, general_purpose_input_one, pin_two_buf_en,
   input wire general_purpose_input_two, headphone_speaker_select, headphone_speaker_valid,
   // selects
   input wire [4:0] playback_preset_block, record_preset_block,
   input wire playback_engine_sel, record_engine_sel
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence play_wr_s; psel && penable && pwrite && paddr == `IPDS_ADDR_PLAY; endsequence
   sequence rec_wr_s; psel && penable && pwrite && paddr == `IPDS_ADDR_REC; endsequence
   pin_one_off_a:
      assert property (!pin_one_buf_en |-> !pin_one_alt_en && !general_purpose_input_one) else $error("pin1 off");
   pin_one_alt_a:
      assert property (pin_one_alt_en |-> pin_one_buf_en && !general_purpose_input_one) else $error("pin1 alt");
   pin_one_gpi_a:
      assert property (general_purpose_input_one |-> pin_one_buf_en && !pin_one_alt_en) else $error("pin1 gpi");
   pin_two_off_a:
      assert property (!pin_two_buf_en |-> !headphone_speaker_valid && !general_purpose_input_two) else $error("pin2");
   hp_select_a:
      assert property (headphone_speaker_valid |-> headphone_speaker_select == aux_input_pin_two) else $error("hpsp");
   play_engine_a:
      assert property (play_wr_s ##0 pwdata[4:0] == 5'h00 |=> playback_engine_sel) else $error("play engine");
   play_preset_a:
      assert property (play_wr_s ##0 pwdata[4:0] - 5'h01 < 5'h19 |=> ##1 playback_preset_block == $past(pwdata[4:0], 2))
      else $error("play preset");
   rec_preset_a:
      assert property (rec_wr_s ##0 pwdata[4:0] inside {[5'h04:5'h06], [5'h0A:5'h0C], [5'h10:5'h12]}
         |=> ##1 record_preset_block == $past(pwdata[4:0], 2)) else $error("rec preset");
   rec_engine_a:
      assert property (rec_wr_s ##0 pwdata[4:0] == 5'h00 |=> record_engine_sel) else $error("rec engine");
endmodule // ipds_props
bind ipds_regs ipds_props props_i (.*);

//--- sim/tb_ipds_regs.sv
`timescale 1ns/1ns
`include "ipds_defs.vh"
module tb_ipds_regs;
   reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, e;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h00000000, q;
   reg [2:0] lvl = 3'h0;
   reg [5:0] x;
   wire aux_input_pin_one, aux_input_pin_two, aux_input_pin_three, pready, pslverr;
   wire [31:0] prdata;
   wire [10:0] o;
   wire [5:0] pb, rb;
   integer fails = 0, cmp_count = 0, m, c;
   always #5 pclk = ~pclk;
   ipds_pins far (.pclk(pclk), .lvl(lvl), .pins({aux_input_pin_three, aux_input_pin_two, aux_input_pin_one}));
   ipds_regs uut (.*, .pin_one_buf_en(o[10]), .pin_one_alt_en(o[9]), .general_purpose_input_one(o[8]),
      .pin_two_buf_en(o[7]), .pin_two_alt_en(o[6]), .general_purpose_input_two(o[5]), .headphone_speaker_valid(o[4]),
      .headphone_speaker_select(o[3]), .pin_three_buf_en(o[2]), .pin_three_alt_en(o[1]),
      .general_purpose_input_three(o[0]), .playback_engine_sel(pb[5]), .playback_preset_block(pb[4:0]),
      .record_engine_sel(rb[5]), .record_preset_block(rb[4:0]));
   function [2:0] f(input integer k);
      f = {k != 0, k == 1, k == 2};
   endfunction
   task chk(input [31:0] s, input [31:0] w);
      cmp_count = cmp_count + 1;
      if (s !== w) begin
         fails = fails + 1;
         $display("ERROR %0t saw %h want %h", $time, s, w);
      end
   endtask
   // entered at a rising edge; holds the request until pready is seen high, for at most 50 edges
   task xfer(input [11:0] a, input w, input [7:0] d);
      integer n;
      n = 0;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1;
      do @(posedge pclk); while (pready !== 1'b1 && ++n < 50);
      if (pready !== 1'b1) fails = fails + 1;
      q = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge pclk);
   endtask
   task results;
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #50000 fails = fails + 1;
      results;
   end
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1;
      for (m = 0; m < 5; m = m + 1) begin
         xfer(12'h0E4 + 4 * m, 0, 8'h00);
         chk(q, m == 3 ? 1 : m == 4 ? 4 : 0);
      end
      lvl <= 3'h7;
      for (m = 0; m < 4; m = m + 1) begin
         c = m % 3;
         xfer(`IPDS_ADDR_PINS12, 1, c * 32 + m * 2);
         xfer(`IPDS_ADDR_PIN3, 1, c * 32);
         chk(o, {f(c), f(m), m == 3, m == 3, f(c)});
         xfer(`IPDS_ADDR_PINS12, 0, 8'h00);
         chk(q, c * 32 + (c != 0) * 16 + m * 2 + (m != 0));
         xfer(`IPDS_ADDR_PIN3, 0, 8'h00);
         chk(q, c * 32 + (c != 0) * 16);
      end
      lvl <= 3'h0;
      xfer(`IPDS_ADDR_PINS12, 1, 8'h55);
      xfer(`IPDS_ADDR_PIN3, 1, 8'h50);
      repeat (4) @(posedge pclk);
      xfer(`IPDS_ADDR_PINS12, 0, 8'h00);
      chk(q, 32'h44);
      xfer(`IPDS_ADDR_PIN3, 0, 8'h00);
      chk(q, 32'h40);
      for (c = 0; c < 64; c = c + 1) begin
         x = {c[4:0] == 0, c[4:0]};
         // reserved codes are never written: software is bound to avoid them
         if (c < 32 ? c <= 25 : (c[4:0] == 0 || c[4:0] inside {[4:6], [10:12], [16:18]})) begin
            xfer(c < 32 ? `IPDS_ADDR_PLAY : `IPDS_ADDR_REC, 1, c[4:0]);
            @(posedge pclk);
            chk(c < 32 ? pb : rb, x);
         end
      end
      xfer(12'h100, 0, 8'h00);
      chk(e, 1);
      chk(q, 0);
      results;
   end
endmodule // tb_ipds_regs

//--- src/ipds_defs.vh
`ifndef IPDS_DEFS_VH
`define IPDS_DEFS_VH

// register indices (printed offsets are not multiples of four)
`define IPDS_IDX_PINS12 8'h39
`define IPDS_IDX_PIN3 8'h3A
`define IPDS_IDX_RSVD 8'h3B
`define IPDS_IDX_PLAY 8'h3C
`define IPDS_IDX_REC 8'h3D

// byte addresses are four times the index
`define IPDS_ADDR_PINS12 12'h0E4
`define IPDS_ADDR_PIN3 12'h0E8
`define IPDS_ADDR_RSVD 12'h0EC
`define IPDS_ADDR_PLAY 12'h0F0
`define IPDS_ADDR_REC 12'h0F4

// field positions
`define IPDS_P1_MODE_HI 6
`define IPDS_P1_MODE_LO 5
`define IPDS_P1_LVL 4
`define IPDS_P2_MODE_HI 2
`define IPDS_P2_MODE_LO 1
`define IPDS_P2_LVL 0
`define IPDS_P3_MODE_HI 6
`define IPDS_P3_MODE_LO 5
`define IPDS_P3_LVL 4

// pin modes
`define IPDS_MODE_OFF 2'h0
`define IPDS_MODE_ALT 2'h1
`define IPDS_MODE_GPI 2'h2
`define IPDS_MODE_HPSP 2'h3

// reset values
`define IPDS_RST_MODE 2'h0
`define IPDS_RST_RSVD_BYTE 8'h00
`define IPDS_RST_PLAY 5'h01
`define IPDS_RST_REC 5'h04
`define IPDS_SEL_ENGINE 5'h00
`define IPDS_PLAY_MAX 5'h19

`endif

//--- src/ipds_regs.v
`timescale 1ns/1ns
`include "ipds_defs.vh"

// Notes on behaviour
// - pin one mode 00 powers buffer down
// - pin one mode 01 enables alternate clock/data use
// - pin one mode 10 is general input; 11 reserved
// - pin two mode 00 powers buffer down
// - pin two mode 01 enables alternate use
// - pin two mode 10 is general input
// - pin two mode 11 is headphone/speaker select
// - pin three mode 00 powers buffer down
// - pin three mode 01 enables alternate use
// - pin three mode 10 general input; 11 reserved
// - playback code zero selects programmable engine
// - playback codes 1-25 select preset; reset one
// - record code zero selects programmable engine
// - record codes 4-6,10-12,16-18 select preset; reset 4
module ipds_regs (
   // apb slave
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output wire pslverr,
   output reg [31:0] prdata,
   // auxiliary pin levels
   input wire aux_input_pin_one,
   input wire aux_input_pin_two,
   input wire aux_input_pin_three,
   // buffer enables
   output wire pin_one_buf_en,
   output wire pin_two_buf_en,
   output wire pin_three_buf_en,
   // alternate-role and general input outputs
   output wire pin_one_alt_en,
   output wire pin_two_alt_en,
   output wire pin_three_alt_en,
   output wire general_purpose_input_one,
   output wire general_purpose_input_two,
   output wire general_purpose_input_three,
   output wire headphone_speaker_select,
   output wire headphone_speaker_valid,
   // processing selection
   output reg [4:0] playback_preset_block,
   output wire playback_engine_sel,
   output reg [4:0] record_preset_block,
   output wire record_engine_sel
);

////////////////////////////////////////////////////////////////////////
reg [1:0] p1_mode_r;
reg [1:0] p2_mode_r;
reg [1:0] p3_mode_r;
reg p1_rsvd_r;
reg p2_rsvd_r;
reg p3_rsvd_r;
reg [3:0] p3_low_r;
reg [7:0] rsvd_byte_r;
reg [2:0] play_hi_r;
reg [2:0] rec_hi_r;
reg [4:0] play_sel_r;
reg [4:0] rec_sel_r;
wire wr_en;
wire hit;
wire lvl1;
wire lvl2;
wire lvl3;
reg [4:0] play_preset_nxt;
reg [4:0] rec_preset_nxt;

// single-cycle access phase; no wait states
assign pready = 1'b1;
assign hit = (paddr == `IPDS_ADDR_PINS12) || (paddr == `IPDS_ADDR_PIN3) || (paddr == `IPDS_ADDR_RSVD) ||
   (paddr == `IPDS_ADDR_PLAY) || (paddr == `IPDS_ADDR_REC);
assign pslverr = psel & penable & ~hit;
assign wr_en = psel & penable & pwrite;

////////////////////////////////////////////////////////////////////////
// reserved bits are stored as written; software is expected to keep them zero
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      p1_mode_r <= `IPDS_RST_MODE;
      p2_mode_r <= `IPDS_RST_MODE;
      p3_mode_r <= `IPDS_RST_MODE;
      p1_rsvd_r <= 1'b0;
      p2_rsvd_r <= 1'b0;
      p3_rsvd_r <= 1'b0;
      p3_low_r <= 4'h0;
      rsvd_byte_r <= `IPDS_RST_RSVD_BYTE;
      play_hi_r <= 3'h0;
      rec_hi_r <= 3'h0;
      play_sel_r <= `IPDS_RST_PLAY;
      rec_sel_r <= `IPDS_RST_REC;
   end else if (wr_en) begin
      case (paddr)
         `IPDS_ADDR_PINS12: begin
            p1_rsvd_r <= pwdata[7];
            p1_mode_r <= pwdata[`IPDS_P1_MODE_HI:`IPDS_P1_MODE_LO];
            p2_rsvd_r <= pwdata[3];
            p2_mode_r <= pwdata[`IPDS_P2_MODE_HI:`IPDS_P2_MODE_LO];
         end
         `IPDS_ADDR_PIN3: begin
            p3_rsvd_r <= pwdata[7];
            p3_mode_r <= pwdata[`IPDS_P3_MODE_HI:`IPDS_P3_MODE_LO];
            p3_low_r <= pwdata[3:0];
         end
         `IPDS_ADDR_RSVD: begin
            rsvd_byte_r <= pwdata[7:0];
         end
         `IPDS_ADDR_PLAY: begin
            play_hi_r <= pwdata[7:5];
            play_sel_r <= pwdata[4:0];
         end
         `IPDS_ADDR_REC: begin
            rec_hi_r <= pwdata[7:5];
            rec_sel_r <= pwdata[4:0];
         end
         default: begin
            p1_mode_r <= p1_mode_r;
         end
      endcase
   end
end

////////////////////////////////////////////////////////////////////////
// reserved code 11 on pins one and three leaves the pin with no role
ipds_pin_mode #(
   .HAS_HPSP(0)
) pin_one_i (
   .mode(p1_mode_r),
   .pin(aux_input_pin_one),
   .buf_en(pin_one_buf_en),
   .alt_en(pin_one_alt_en),
   .general_purpose_input(general_purpose_input_one),
   .hp_valid(),
   .hp_sel(),
   .lvl(lvl1)
);

ipds_pin_mode #(
   .HAS_HPSP(1)
) pin_two_i (
   .mode(p2_mode_r),
   .pin(aux_input_pin_two),
   .buf_en(pin_two_buf_en),
   .alt_en(pin_two_alt_en),
   .general_purpose_input(general_purpose_input_two),
   .hp_valid(headphone_speaker_valid),
   .hp_sel(headphone_speaker_select),
   .lvl(lvl2)
);

ipds_pin_mode #(
   .HAS_HPSP(0)
) pin_three_i (
   .mode(p3_mode_r),
   .pin(aux_input_pin_three),
   .buf_en(pin_three_buf_en),
   .alt_en(pin_three_alt_en),
   .general_purpose_input(general_purpose_input_three),
   .hp_valid(),
   .hp_sel(),
   .lvl(lvl3)
);

////////////////////////////////////////////////////////////////////////
assign playback_engine_sel = (play_sel_r == `IPDS_SEL_ENGINE);
assign record_engine_sel = (rec_sel_r == `IPDS_SEL_ENGINE);

// reserved codes map to zero so no undefined block is ever handed on
always @* begin
   play_preset_nxt = 5'h00;
   rec_preset_nxt = 5'h00;
   if (play_sel_r <= `IPDS_PLAY_MAX) begin
      play_preset_nxt = play_sel_r;
   end
   case (rec_sel_r)
      5'h04,
      5'h05,
      5'h06,
      5'h0A,
      5'h0B,
      5'h0C,
      5'h10,
      5'h11,
      5'h12: begin
         rec_preset_nxt = rec_sel_r;
      end
      default: begin
         rec_preset_nxt = 5'h00;
      end
   endcase
end

// preset number registered one cycle behind the select code; zero from the cycle after the engine is selected
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      playback_preset_block <= `IPDS_RST_PLAY;
      record_preset_block <= `IPDS_RST_REC;
   end else begin
      playback_preset_block <= play_preset_nxt;
      record_preset_block <= rec_preset_nxt;
   end
end

////////////////////////////////////////////////////////////////////////
// read data registered in the setup cycle, valid in the access phase
always @(posedge pclk or negedge presetn) begin
   if (!presetn) begin
      prdata <= 32'h00000000;
   end else if (psel && !penable && !pwrite) begin
      case (paddr)
         `IPDS_ADDR_PINS12: begin
            prdata <= {24'h000000, p1_rsvd_r, p1_mode_r, lvl1, p2_rsvd_r, p2_mode_r, lvl2};
         end
         `IPDS_ADDR_PIN3: begin
            prdata <= {24'h000000, p3_rsvd_r, p3_mode_r, lvl3, p3_low_r};
         end
         `IPDS_ADDR_RSVD: begin
            prdata <= {24'h000000, rsvd_byte_r};
         end
         `IPDS_ADDR_PLAY: begin
            prdata <= {24'h000000, play_hi_r, play_sel_r};
         end
         `IPDS_ADDR_REC: begin
            prdata <= {24'h000000, rec_hi_r, rec_sel_r};
         end
         default: begin
            prdata <= 32'h00000000;
         end
      endcase
   end
end

endmodule // ipds_regs

////////////////////////////////////////////////////////////////////////
// one auxiliary input pin: buffer power, role decode and gated level
module ipds_pin_mode #(
   parameter HAS_HPSP = 0
) (
   // mode field
   input wire [1:0] mode,
   // pad level
   input wire pin,
   // decoded roles
   output wire buf_en,
   output wire alt_en,
   output wire general_purpose_input,
   output wire hp_valid,
   output wire hp_sel,
   output wire lvl
);

// a powered-down buffer reads as zero rather than floating
assign buf_en = (mode != `IPDS_MODE_OFF);
assign lvl = pin & buf_en;
assign alt_en = (mode == `IPDS_MODE_ALT);
assign general_purpose_input = (mode == `IPDS_MODE_GPI) & lvl;
// code 11 is a role only on the pin that has one; elsewhere the buffer stays powered but no role output is raised
assign hp_valid = (HAS_HPSP != 0) && (mode == `IPDS_MODE_HPSP);
assign hp_sel = hp_valid & lvl;

endmodule // ipds_pin_mode
